// ---- inc/sideband_pkg.sv ----
// shared constants and types for the hub sideband pin logic
`default_nettype none
package sideband_pkg;
  // clock
  localparam int CLK_MHZ = 125;
  // remote wakeup pulse on the indicator pin
  localparam int WAKE_PULSE_US     = 10;
  localparam int WAKE_PULSE_CYCLES = WAKE_PULSE_US * CLK_MHZ;
  localparam int WAKE_CNT_W        = 11;
  // led timing
  localparam int              LED_TICK_US            = 1000;
  localparam int              LED_TICK_CYCLES        = LED_TICK_US * CLK_MHZ;
  localparam int              LED_PRESCALE_W         = 17;
  localparam int              LED_STEP_W             = 9;
  localparam logic [8:0]      LED_BLINK_BASE_TICKS   = 9'h020;
  localparam logic [8:0]      LED_BREATHE_BASE_TICKS = 9'h001;
  // register port
  localparam int              REG_ADDR_W    = 8;
  localparam logic [7:0]      CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]      STATUS_OFFSET = 8'h04;
  localparam int              CTRL_WAKE_MODE_BIT   = 0;
  localparam int              CTRL_LED_EN_BIT      = 1;
  localparam int              CTRL_LED_BREATHE_BIT = 2;
  localparam int              CTRL_LED_RATE_LSB    = 3;
  localparam logic            WAKE_MODE_RESET      = 1'b0;
  localparam logic            LED_EN_RESET         = 1'b0;
  localparam logic            LED_BREATHE_RESET    = 1'b0;
  localparam logic [1:0]      LED_RATE_RESET       = 2'h0;
  localparam int              STAT_SELF_POWER_BIT  = 0;
  localparam int              STAT_VBUS_BIT        = 1;
  localparam int              STAT_STRAP_BIT       = 2;
  localparam int              STAT_IND_PIN_BIT     = 3;
  localparam int              STAT_SPEED_BIT       = 4;
  localparam int              STAT_WAKE_BUSY_BIT   = 5;
  // synchronised pins
  localparam int              PIN_W         = 4;
  localparam int              PIN_SELF_PWR  = 0;
  localparam int              PIN_VBUS      = 1;
  localparam int              PIN_STRAP     = 2;
  localparam int              PIN_IND       = 3;
  localparam logic [3:0]      PIN_RESET     = 4'h0;
  // indicator pin after reset: driven low, i.e. unconfigured
  localparam logic            IND_OE_N_RESET = 1'b0;
  typedef enum logic {WAKE_IDLE, WAKE_PULSE} wake_state_type;
endpackage
`default_nettype wire

// ---- verilog/led_pattern.sv ----
// general purpose led pattern generator: blink or breathe at four rates
`default_nettype none
module led_pattern
  import sideband_pkg::*;
#(
  parameter int TICK_CYCLES = LED_TICK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       enable_i,
  input  wire logic       breathe_i,
  input  wire logic [1:0] rate_i,
  output var  logic       led_o
);
  logic [LED_PRESCALE_W-1:0] presc;
  logic [LED_PRESCALE_W-1:0] next_presc;
  logic [LED_STEP_W-1:0]     step;
  logic [LED_STEP_W-1:0]     next_step;
  logic [LED_STEP_W-1:0]     limit;
  logic [7:0]                level;
  logic [7:0]                next_level;
  logic [7:0]                pwm;
  logic [7:0]                next_pwm;
  logic                      up;
  logic                      next_up;
  logic                      blink;
  logic                      next_blink;
  logic                      next_led;
  logic                      tick;
  logic                      step_due;

  always_comb begin
    tick       = presc == LED_PRESCALE_W'(TICK_CYCLES - 1);
    limit      = ((breathe_i ? LED_BREATHE_BASE_TICKS : LED_BLINK_BASE_TICKS) << rate_i) - 9'h001;
    step_due   = tick && (step == limit);
    next_presc = tick ? '0 : presc + 1'b1;
    next_step  = step_due ? '0 : (tick ? step + 1'b1 : step);
    next_pwm   = pwm + 8'h01;
    next_blink = blink ^ step_due;
    next_up    = up;
    next_level = level;
    if (step_due && breathe_i) begin
      if (up) begin
        next_level = level + 8'h01;
        next_up    = level != 8'hfe;
      end else begin
        next_level = level - 8'h01;
        next_up    = level == 8'h01;
      end
    end
    // breathe is pwm against a ramping level; pwm runs far above flicker rate
    next_led = breathe_i ? (pwm < level) : blink;
    if (!enable_i) begin
      // unused until enabled: pattern restarts from dark each time
      next_presc = '0;
      next_step  = '0;
      next_level = '0;
      next_up    = 1'b1;
      next_blink = 1'b0;
      next_led   = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      presc <= '0;
      step  <= '0;
      level <= '0;
      pwm   <= '0;
      up    <= 1'b1;
      blink <= 1'b0;
      led_o <= 1'b0;
    end else begin
      presc <= next_presc;
      step  <= next_step;
      level <= next_level;
      pwm   <= next_pwm;
      up    <= next_up;
      blink <= next_blink;
      led_o <= next_led;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  led_off_disabled_a: assert property (
    !enable_i |=> !led_o) else $error("led lit while disabled");
  breathe_turn_a: assert property (
    enable_i && breathe_i && step_due && up && level == 8'hfe |=> !up && level == 8'hff)
    else $error("breathe ramp did not turn at top");
endmodule
`default_nettype wire

// ---- verilog/hub_sideband_status_pins.sv ----
// hub sideband pins: reset, suspend/wake indicator, speed indicator, power detects, led
`default_nettype none
module hub_sideband_status_pins
  import sideband_pkg::*;
#(
  parameter int LED_TICK = LED_TICK_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ext_reset_n_i,
  input  wire logic                  self_power_detect_i,
  input  wire logic                  upstream_power_detect_i,
  input  wire logic                  config_method_strap_hi_i,
  input  wire logic                  suspend_wake_indicator_i,
  input  wire logic                  hub_configured_i,
  input  wire logic                  hub_suspended_i,
  input  wire logic                  link_high_speed_i,
  input  wire logic                  remote_wake_event_i,
  input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_write_i,
  input  wire logic                  reg_read_i,
  output var  logic [31:0]           reg_rdata_o,
  output var  logic                  suspend_wake_indicator_o,
  output var  logic                  suspend_wake_indicator_oe_n_o,
  output var  logic                  upstream_speed_indicator_o,
  output var  logic                  general_led_out_o,
  output var  logic                  self_powered_o,
  output var  logic                  upstream_power_present_o,
  output var  logic                  reconnect_request_o,
  output var  logic                  core_reset_n_o
);
  logic                  rst_meta;
  logic                  rst_sync;
  logic                  core_rst_n;
  logic [PIN_W-1:0]      pin_meta;
  logic [PIN_W-1:0]      pin_sync;
  logic                  wake_mode;
  logic                  next_wake_mode;
  logic                  led_en;
  logic                  next_led_en;
  logic                  led_breathe;
  logic                  next_led_breathe;
  logic [1:0]            led_rate;
  logic [1:0]            next_led_rate;
  logic [31:0]           next_rdata;
  logic                  strap_valid;
  logic                  strap_latched;
  logic                  next_strap_latched;
  logic                  next_speed;
  logic                  hs_active;
  logic                  next_reconnect;
  wake_state_type        wake_state;
  wake_state_type        next_wake_state;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic [WAKE_CNT_W-1:0] next_wake_cnt;
  logic                  next_oe_n;
  logic [1:0]            strap_wait;
  logic [1:0]            next_strap_wait;
  logic [WAKE_CNT_W-1:0] wake_low_run;
  logic [WAKE_CNT_W-1:0] next_wake_low_run;

  // reset pin: clears at once, releases through two flops so no output sees a runt edge
  always_ff @(posedge clk_i or negedge ext_reset_n_i) begin
    if (!ext_reset_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    core_rst_n     <= rst_n_i && rst_sync;
    core_reset_n_o <= rst_n_i && rst_sync;
  end

  // board pins are asynchronous; nothing reads pin_meta except pin_sync
  always_ff @(posedge clk_i) begin
    if (!core_rst_n) begin
      pin_meta <= PIN_RESET;
      pin_sync <= PIN_RESET;
    end else begin
      pin_meta <= {suspend_wake_indicator_i, config_method_strap_hi_i,
                   upstream_power_detect_i, self_power_detect_i};
      pin_sync <= pin_meta;
    end
  end

  // register port
  always_comb begin
    next_wake_mode   = wake_mode;
    next_led_en      = led_en;
    next_led_breathe = led_breathe;
    next_led_rate    = led_rate;
    next_rdata       = 32'h0000_0000;
    if (reg_write_i && reg_addr_i == CTRL_OFFSET) begin
      next_wake_mode   = reg_wdata_i[CTRL_WAKE_MODE_BIT];
      next_led_en      = reg_wdata_i[CTRL_LED_EN_BIT];
      next_led_breathe = reg_wdata_i[CTRL_LED_BREATHE_BIT];
      next_led_rate    = reg_wdata_i[CTRL_LED_RATE_LSB +: 2];
    end
    if (reg_read_i) begin
      if (reg_addr_i == CTRL_OFFSET) begin
        next_rdata[CTRL_WAKE_MODE_BIT]      = wake_mode;
        next_rdata[CTRL_LED_EN_BIT]         = led_en;
        next_rdata[CTRL_LED_BREATHE_BIT]    = led_breathe;
        next_rdata[CTRL_LED_RATE_LSB +: 2]  = led_rate;
      end else if (reg_addr_i == STATUS_OFFSET) begin
        next_rdata[STAT_SELF_POWER_BIT] = self_powered_o;
        next_rdata[STAT_VBUS_BIT]       = upstream_power_present_o;
        next_rdata[STAT_STRAP_BIT]      = strap_latched;
        next_rdata[STAT_IND_PIN_BIT]    = pin_sync[PIN_IND];
        next_rdata[STAT_SPEED_BIT]      = upstream_speed_indicator_o;
        next_rdata[STAT_WAKE_BUSY_BIT]  = wake_state == WAKE_PULSE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!core_rst_n) begin
      wake_mode   <= WAKE_MODE_RESET;
      led_en      <= LED_EN_RESET;
      led_breathe <= LED_BREATHE_RESET;
      led_rate    <= LED_RATE_RESET;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      wake_mode   <= next_wake_mode;
      led_en      <= next_led_en;
      led_breathe <= next_led_breathe;
      led_rate    <= next_led_rate;
      reg_rdata_o <= next_rdata;
    end
  end

  // power detects and reconnect on a new rise of upstream power
  always_comb begin
    next_reconnect = pin_sync[PIN_VBUS] && !upstream_power_present_o;
  end

  always_ff @(posedge clk_i) begin
    if (!core_rst_n) begin
      self_powered_o           <= 1'b0;
      upstream_power_present_o <= 1'b0;
      reconnect_request_o      <= 1'b0;
    end else begin
      self_powered_o           <= pin_sync[PIN_SELF_PWR];
      upstream_power_present_o <= pin_sync[PIN_VBUS];
      reconnect_request_o      <= next_reconnect;
    end
  end

  // speed indicator; the strap is caught once, after release
  // pin_sync holds its reset value for two cycles after release, so capture waits for it to fill
  always_comb begin
    next_strap_wait    = {strap_wait[0], 1'b1};
    next_strap_latched = strap_valid ? strap_latched : pin_sync[PIN_STRAP];
    // with upstream power gone the link has dropped, so high speed is not claimed
    hs_active          = link_high_speed_i && upstream_power_present_o && strap_valid;
    next_speed         = strap_valid ? (hs_active ^ strap_latched) : 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!core_rst_n) begin
      strap_wait                 <= 2'h0;
      strap_valid                <= 1'b0;
      strap_latched              <= 1'b0;
      upstream_speed_indicator_o <= 1'b0;
    end else begin
      strap_wait                 <= next_strap_wait;
      strap_valid                <= strap_wait[1];
      strap_latched              <= next_strap_latched;
      upstream_speed_indicator_o <= next_speed;
    end
  end

  // suspend / wake indicator, open drain: released reads high through the pull-up
  always_comb begin
    next_wake_state = wake_state;
    next_wake_cnt   = wake_cnt;
    unique case (wake_state)
      WAKE_IDLE: begin
        if (wake_mode && remote_wake_event_i) begin
          next_wake_state = WAKE_PULSE;
          next_wake_cnt   = '0;
        end
      end
      WAKE_PULSE: begin
        next_wake_cnt = wake_cnt + 1'b1;
        if (wake_cnt == WAKE_CNT_W'(WAKE_PULSE_CYCLES - 1)) begin
          next_wake_state = WAKE_IDLE;
        end
      end
    endcase
    if (wake_mode) begin
      next_oe_n = next_wake_state != WAKE_PULSE;
    end else begin
      next_oe_n = hub_configured_i && !hub_suspended_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!core_rst_n) begin
      wake_state                    <= WAKE_IDLE;
      wake_cnt                      <= '0;
      suspend_wake_indicator_oe_n_o <= IND_OE_N_RESET;
      suspend_wake_indicator_o      <= 1'b0;
    end else begin
      wake_state                    <= next_wake_state;
      wake_cnt                      <= next_wake_cnt;
      suspend_wake_indicator_oe_n_o <= next_oe_n;
      suspend_wake_indicator_o      <= 1'b0;
    end
  end

  led_pattern #(
    .TICK_CYCLES (LED_TICK)
  ) led_gen (
    .clk_i     (clk_i),
    .rst_n_i   (core_rst_n),
    .enable_i  (led_en),
    .breathe_i (led_breathe),
    .rate_i    (led_rate),
    .led_o     (general_led_out_o)
  );

  // assertion helper: cycles the current wake pulse has held the pin low
  always_comb begin
    next_wake_low_run = (wake_state == WAKE_PULSE && !suspend_wake_indicator_oe_n_o) ? wake_low_run + 1'b1 : '0;
  end

  always_ff @(posedge clk_i) begin
    if (!core_rst_n) begin
      wake_low_run <= '0;
    end else begin
      wake_low_run <= next_wake_low_run;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!core_rst_n);

  sequence wake_start_s;
    wake_mode && wake_state == WAKE_IDLE && remote_wake_event_i;
  endsequence
  sequence wake_last_s;
    wake_mode && !suspend_wake_indicator_oe_n_o && wake_low_run == WAKE_CNT_W'(WAKE_PULSE_CYCLES - 1);
  endsequence

  // the reset itself must not cancel this check, so the default disable is overridden
  reset_outputs_a: assert property (disable iff (1'b0)
    core_rst_n && !rst_sync |=> !core_rst_n ##1 (!upstream_speed_indicator_o && !general_led_out_o
      && !suspend_wake_indicator_oe_n_o && !reconnect_request_o))
    else $error("outputs not inactive after reset");
  status_high_a: assert property (
    !wake_mode && hub_configured_i && !hub_suspended_i |=> suspend_wake_indicator_oe_n_o)
    else $error("indicator not released while configured and active");
  status_low_a: assert property (
    !wake_mode && !(hub_configured_i && !hub_suspended_i) |=> !suspend_wake_indicator_oe_n_o)
    else $error("indicator not driven low while unconfigured or suspended");
  wake_start_a: assert property (
    wake_start_s |=> !suspend_wake_indicator_oe_n_o) else $error("wake pulse did not start");
  wake_end_a: assert property (
    wake_last_s |=> suspend_wake_indicator_oe_n_o || !wake_mode) else $error("wake pulse length wrong");
  speed_polarity_a: assert property (
    strap_valid |=> upstream_speed_indicator_o ==
      ($past(link_high_speed_i && upstream_power_present_o) ^ strap_latched))
    else $error("speed indicator polarity wrong");
  speed_detach_a: assert property (
    strap_valid && !upstream_power_present_o |=> upstream_speed_indicator_o == strap_latched)
    else $error("speed indicator asserted without upstream link");
  strap_stable_a: assert property (
    strap_valid |=> $stable(strap_latched)) else $error("strap changed after capture");
  self_power_a: assert property (
    self_power_detect_i[*3] |=> self_powered_o) else $error("self power not reported");
  vbus_follow_a: assert property (
    (!upstream_power_detect_i)[*3] |=> !upstream_power_present_o)
    else $error("upstream power loss not reported");
  reconnect_pulse_a: assert property (
    reconnect_request_o |-> upstream_power_present_o && !$past(upstream_power_present_o)
      ##1 !reconnect_request_o)
    else $error("reconnect pulse wrong");
endmodule
`default_nettype wire

// ---- verification/board_model.sv ----
// board-side model: reset button, power detect dividers, config strap and indicator pull-up
`default_nettype none
module board_model (
  input  wire logic clk_i,
  input  wire logic ind_data_i,
  input  wire logic ind_oe_n_i,
  output var  logic ext_reset_n_o,
  output var  logic self_power_detect_o,
  output var  logic upstream_power_detect_o,
  output var  logic config_method_strap_hi_o,
  output wire logic ind_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // 5 us of 8 ns cycles
  localparam int RESET_HOLD = 625;
  // open-drain line with a pull-up: a released pin reads high, never the last driven value
  assign ind_wire_o = ind_oe_n_i ? 1'b1 : ind_data_i;
  initial begin
    ext_reset_n_o            = 1'b1;
    self_power_detect_o      = 1'b0;
    upstream_power_detect_o  = 1'b0;
    config_method_strap_hi_o = 1'b0;
  end
  task automatic set_pins(input logic self_pwr, input logic vbus, input logic strap);
    self_power_detect_o      <= self_pwr;
    upstream_power_detect_o  <= vbus;
    config_method_strap_hi_o <= strap;
  endtask
  // called right after an edge; the pin never comes back early
  task automatic reset_pulse();
    ext_reset_n_o <= 1'b0;
    repeat (RESET_HOLD) @(posedge clk_i);
    ext_reset_n_o <= 1'b1;
  endtask
  // host side drops upstream power long enough to be seen, then restores it
  task automatic power_toggle(input int low_cycles);
    upstream_power_detect_o <= 1'b0;
    repeat (low_cycles) @(posedge clk_i);
    upstream_power_detect_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the hub sideband pin logic
`default_nettype none
module tb
  import sideband_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic              clk_i;
  logic              rst_n_i;
  logic              hub_configured;
  logic              hub_suspended;
  logic              link_high_speed;
  logic              remote_wake_event;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_write;
  logic              reg_read;
  wire  logic [31:0] reg_rdata;
  wire  logic        ind_data, ind_oe_n, ind_wire, speed, led, self_powered, power_present, reconnect, core_rst_n;
  wire  logic        ext_rst_n, self_pwr, vbus, strap;
  int                errors;
  int                check_count;
  int                reconnect_cycles;
  int                n;

  hub_sideband_status_pins #(.LED_TICK(TICK)) dut_u (
    .clk_i                         (clk_i),
    .rst_n_i                       (rst_n_i),
    .ext_reset_n_i                 (ext_rst_n),
    .self_power_detect_i           (self_pwr),
    .upstream_power_detect_i       (vbus),
    .config_method_strap_hi_i      (strap),
    .suspend_wake_indicator_i      (ind_wire),
    .hub_configured_i              (hub_configured),
    .hub_suspended_i               (hub_suspended),
    .link_high_speed_i             (link_high_speed),
    .remote_wake_event_i           (remote_wake_event),
    .reg_addr_i                    (reg_addr),
    .reg_wdata_i                   (reg_wdata),
    .reg_write_i                   (reg_write),
    .reg_read_i                    (reg_read),
    .reg_rdata_o                   (reg_rdata),
    .suspend_wake_indicator_o      (ind_data),
    .suspend_wake_indicator_oe_n_o (ind_oe_n),
    .upstream_speed_indicator_o    (speed),
    .general_led_out_o             (led),
    .self_powered_o                (self_powered),
    .upstream_power_present_o      (power_present),
    .reconnect_request_o           (reconnect),
    .core_reset_n_o                (core_rst_n)
  );
  board_model board_u (
    .clk_i                    (clk_i),
    .ind_data_i               (ind_data),
    .ind_oe_n_i               (ind_oe_n),
    .ext_reset_n_o            (ext_rst_n),
    .self_power_detect_o      (self_pwr),
    .upstream_power_detect_o  (vbus),
    .config_method_strap_hi_o (strap),
    .ind_wire_o               (ind_wire)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // a pulse held longer than one cycle shows up as an extra count
  always @(posedge clk_i) if (reconnect === 1'b1) reconnect_cycles++;

  task automatic summarize();
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_i);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_i);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge clk_i);
  endtask
  task automatic led_ones(input int c, output int cnt);
    cnt = 0;
    repeat (c) begin
      @(posedge clk_i);
      #1 cnt += (led === 1'b1);
    end
  endtask
  // skips the first, possibly partial, half period and counts the next one
  task automatic half_period(output int cnt);
    logic v;
    int   g;
    #1 v = led;
    g = 0;
    while (led === v && g < 9000) begin
      @(posedge clk_i);
      #1 g++;
    end
    v = led;
    cnt = 0;
    while (led === v && cnt < 9000) begin
      @(posedge clk_i);
      #1 cnt++;
    end
  endtask
  task automatic speed_check(input logic s);
    for (int h = 0; h < 2; h++) begin
      link_high_speed <= h[0];
      cyc(2);
      #1 check(speed, h[0] ^ s);
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    summarize();
  end

  initial begin
    {rst_n_i, hub_configured, hub_suspended, link_high_speed, remote_wake_event, reg_write, reg_read} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    errors = 0;
    check_count = 0;
    reconnect_cycles = 0;
    cyc(16);
    rst_n_i <= 1'b1;
    cyc(3);
    #1 check({core_rst_n, ind_oe_n, speed, led, self_powered, power_present}, 32'h20);
    reg_rd(CTRL_OFFSET, 32'h0);
    reg_wr(CTRL_OFFSET, 32'h1e);
    reg_rd(CTRL_OFFSET, 32'h1e);
    #1 check(reg_rdata, 32'h0);
    reg_wr(STATUS_OFFSET, 32'hff);
    reg_rd(STATUS_OFFSET, 32'h0);
    reg_wr(8'h08, 32'h1);
    reg_rd(8'h08, 32'h0);
    reg_wr(CTRL_OFFSET, 32'h0);
    board_u.set_pins(1'b1, 1'b1, 1'b0);
    cyc(4);
    #1 check({self_powered, power_present, reconnect_cycles[1:0]}, 4'hd);
    reg_rd(STATUS_OFFSET, 32'h3);
    board_u.power_toggle(4);
    cyc(4);
    #1 check({core_rst_n, power_present, reconnect_cycles[1:0]}, 4'he);
    speed_check(1'b0);
    reg_rd(STATUS_OFFSET, 32'h13);
    for (int i = 0; i < 4; i++) begin
      {hub_configured, hub_suspended} <= i[1:0];
      cyc(2);
      #1 check({ind_data, ind_oe_n, ind_wire}, {1'b0, i == 2, i == 2});
    end
    // a wake event in status mode must not disturb the indicator
    {hub_configured, hub_suspended} <= 2'b10;
    remote_wake_event <= 1'b1;
    cyc(1);
    remote_wake_event <= 1'b0;
    cyc(3);
    #1 check(ind_oe_n, 1'b1);
    reg_wr(CTRL_OFFSET, 32'h1);
    cyc(2);
    remote_wake_event <= 1'b1;
    cyc(1);
    remote_wake_event <= 1'b0;
    n = 0;
    // a second event in mid-pulse must neither restart nor stretch it
    // the pin goes low at the edge that takes the event, so sampling starts right there
    for (int k = 0; k < 1400; k++) begin
      #1 n += (ind_oe_n === 1'b0);
      remote_wake_event <= (k == 600);
      @(posedge clk_i);
    end
    check(n, WAKE_PULSE_CYCLES);
    for (int r = 0; r < 4; r++) begin
      reg_wr(CTRL_OFFSET, 32'h2 | (r << 3));
      half_period(n);
      check(n, (32 << r) * TICK);
    end
    reg_wr(CTRL_OFFSET, 32'h6);
    led_ones(3000, n);
    check(n > 0 && n < 3000, 1'b1);
    reg_wr(CTRL_OFFSET, 32'h0);
    cyc(2);
    led_ones(200, n);
    check(n, 0);
    reg_wr(CTRL_OFFSET, 32'h3);
    board_u.set_pins(1'b1, 1'b1, 1'b1);
    link_high_speed <= 1'b1;
    cyc(2);
    board_u.reset_pulse();
    #1 check({core_rst_n, ind_oe_n, speed, led, reconnect}, 5'h0);
    cyc(4);
    reg_rd(CTRL_OFFSET, 32'h0);
    speed_check(1'b1);
    reg_rd(STATUS_OFFSET, 32'h0f);
    summarize();
  end
endmodule
`default_nettype wire
